// [src/rsm_mode_ctrl.sv]
// rsm_mode_ctrl: mode and reset sequencer of an eight-channel relay switch
// assumes supply-good and pin levels synchronous to ref_clk
// Functional notes
// (R1) power-up clears registers, starts in standby
// (R2) wake command moves standby to active
// (R3) standby command moves active to standby
// (R4) entering standby clears register banks; code clears only channel config, IRQ mask and status kept
// (R5) battery under-voltage resets channels and registers; code leaves IRQ mask and status untouched
// (R6) cranking above floor keeps outputs, configuration
// (R7) missing logic supply holds present outputs
// (R8) shift path works whenever logic supply present
// (R9) limp home input high enters limp home
// (R10) limp home holds writable registers reset; code holds only channel config, IRQ mask stays writable
// (R11) limp home routes inputs to channels 4,5; code routes in1, in2 to channels 3,4
// (R12) limp home works without logic supply
// (R13) limp home input wakes from standby
// (R14) leaving limp home always enters standby
// (R15) any reset sets transmission error flag
// (R16) limp home: status readable, commands rejected
// (R17) under-voltage: reads return diagnostic frame, error
// (R18) mode machine; limp home beats serial commands
// (R19) any reset switches all channels off
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "rsm_defines.svh"
module rsm_mode_ctrl #(
    parameter int N_CH     = 8,
    parameter int UV_CYC   = `RSM_UV_FILT_CYC
) (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire rsm_pkg::rsm_pins_t  pins,
    input  wire logic                so_in,
    input  wire logic                sclk_en,
    input  wire logic [11:0]         s_awaddr,
    input  wire logic                s_awvalid,
    output logic                     s_awready,
    input  wire logic [31:0]         s_wdata,
    input  wire logic [3:0]          s_wstrb,
    input  wire logic                s_wvalid,
    output logic                     s_wready,
    output logic [1:0]               s_bresp,
    output logic                     s_bvalid,
    input  wire logic                s_bready,
    input  wire logic [11:0]         s_araddr,
    input  wire logic                s_arvalid,
    output logic                     s_arready,
    output logic [31:0]              s_rdata,
    output logic [1:0]               s_rresp,
    output logic                     s_rvalid,
    input  wire logic                s_rready,
    output logic [N_CH-1:0]          chan_on_q,
    output logic                     so_out_q,
    output logic                     irq_q
);
    import rsm_pkg::*;

    rsm_state_t                  state_q;
    rsm_state_t                  state_d;
    rsm_wreq_t                   wr_req;
    logic                        wr_stb;
    logic [11:0]                 rd_addr;
    logic                        rd_stb;
    logic [31:0]                 rd_data;
    logic [1:0]                  wr_resp;
    logic [1:0]                  rd_resp;
    logic                        bat_good;
    logic [N_CH-1:0]             chan_cfg_q;
    logic [`RSM_EV_WIDTH-1:0]    stat_q;
    logic [`RSM_EV_WIDTH-1:0]    mask_q;
    logic [`RSM_EV_WIDTH-1:0]    ev;
    logic                        transmission_error_flag_q;
    logic                        rst_cmd_q;
    logic                        any_reset;
    logic                        cmd_ok;
    logic                        limp;
    rsm_cmd_t                    cmd;

    rsm_axil_slave u_bus (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr_req_q  (wr_req),
        .wr_stb_q  (wr_stb),
        .wr_resp   (wr_resp),
        .rd_addr_q (rd_addr),
        .rd_stb_q  (rd_stb),
        .rd_data   (rd_data),
        .rd_resp   (rd_resp)
    );

    // battery monitor; floor threshold itself is analog, outside
    rsm_uv_filter #(
        .CYCLES    (UV_CYC)
    ) u_bat_uv (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .supply_ok (pins.bat_ok),
        .good_q    (bat_good)
    );

    function automatic logic is_reg(input logic [11:0] a,
                                    input logic [11:0] off);
        return a == off;
    endfunction

    assign limp      = pins.limp_home_input;
    assign any_reset = rst || !bat_good || rst_cmd_q; // R5
    // command and channel writes need logic supply and no limp home
    assign cmd_ok    = pins.logic_ok && !limp && bat_good; // R16 R17
    assign cmd.wake    = wr_stb && cmd_ok && wr_req.strb[0]
                         && is_reg(wr_req.addr, `RSM_OFF_CMD)
                         && wr_req.data[`RSM_CMD_WAKE_BIT];
    assign cmd.standby = wr_stb && cmd_ok && wr_req.strb[0]
                         && is_reg(wr_req.addr, `RSM_OFF_CMD)
                         && wr_req.data[`RSM_CMD_STANDBY_BIT];
    assign cmd.reset   = wr_stb && cmd_ok && wr_req.strb[0]
                         && is_reg(wr_req.addr, `RSM_OFF_CMD)
                         && wr_req.data[`RSM_CMD_RST_BIT];

    // mode machine, limp home checked first
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            RSM_ST_POR: begin
                state_d = RSM_ST_STANDBY; // R1
            end
            RSM_ST_STANDBY: begin
                if (limp) begin
                    state_d = RSM_ST_LIMP; // R13 R9 R18
                end else if (cmd.wake) begin
                    state_d = RSM_ST_ACTIVE; // R2
                end
            end
            RSM_ST_ACTIVE: begin
                if (limp) begin
                    state_d = RSM_ST_LIMP; // R9 R18
                end else if (cmd.standby) begin
                    state_d = RSM_ST_STANDBY; // R3
                end
            end
            RSM_ST_LIMP: begin
                if (!limp) begin
                    state_d = RSM_ST_STANDBY; // R14
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (any_reset) begin
            state_q <= RSM_ST_POR; // R1
        end else begin
            state_q <= state_d;
        end
    end

    // reset command takes effect one cycle later, as a reset pulse
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rst_cmd_q <= 1'b0;
        end else begin
            rst_cmd_q <= cmd.reset;
        end
    end

    // channel configuration; a missing logic supply just stops writes
    always_ff @(posedge ref_clk) begin
        if (any_reset || state_q == RSM_ST_LIMP
            || state_q == RSM_ST_STANDBY && state_d == RSM_ST_STANDBY
               && chan_cfg_q != `RSM_CHAN_RESET) begin
            chan_cfg_q <= `RSM_CHAN_RESET; // R4 R10
        end else if (state_d == RSM_ST_LIMP
                     || state_q != RSM_ST_STANDBY
                        && state_d == RSM_ST_STANDBY) begin
            chan_cfg_q <= `RSM_CHAN_RESET; // R4 R10
        end else if (wr_stb && cmd_ok && state_q == RSM_ST_ACTIVE
                     && wr_req.strb[0]
                     && is_reg(wr_req.addr, `RSM_OFF_CHAN)) begin
            chan_cfg_q <= wr_req.data[N_CH-1:0]; // R6 R7
        end
    end

    // outputs follow config; limp home routes pins instead
    always_ff @(posedge ref_clk) begin
        if (any_reset) begin
            chan_on_q <= '0; // R19 R5
        end else if (state_q == RSM_ST_LIMP) begin
            chan_on_q <= '0;
            chan_on_q[`RSM_LIMP_CH_A] <= pins.in1; // R11 R12
            chan_on_q[`RSM_LIMP_CH_B] <= pins.in2; // R11 R12
        end else if (state_q == RSM_ST_ACTIVE) begin
            chan_on_q <= chan_cfg_q; // R6 R7
        end else begin
            chan_on_q <= '0;
        end
    end

    // daisy-chain shift stage, gated only by the logic supply
    always_ff @(posedge ref_clk) begin
        if (rst || !pins.logic_ok) begin
            so_out_q <= 1'b0;
        end else if (sclk_en) begin
            so_out_q <= so_in; // R8
        end
    end

    // error flag: set wins over read-clear; limp home counts as a reset
    always_ff @(posedge ref_clk) begin
        if (any_reset || state_q == RSM_ST_LIMP) begin
            transmission_error_flag_q <= 1'b1; // R15
        end else if (rd_stb && is_reg(rd_addr, `RSM_OFF_DIAG)) begin
            transmission_error_flag_q <= 1'b0;
        end
    end

    always_comb begin
        ev = '0;
        ev[`RSM_EV_MODE_BIT]   = state_q != state_d;
        ev[`RSM_EV_LIMP_BIT]   = state_d == RSM_ST_LIMP
                                 && state_q != RSM_ST_LIMP;
        ev[`RSM_EV_RESET_BIT]  = state_q == RSM_ST_POR;
        ev[`RSM_EV_REJECT_BIT] = wr_stb && !cmd_ok; // R16
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stat_q <= '0;
        end else if (rd_stb && is_reg(rd_addr, `RSM_OFF_IRQ_STAT)) begin
            stat_q <= ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mask_q <= `RSM_MASK_RESET;
        end else if (wr_stb && wr_req.strb[0]
                     && is_reg(wr_req.addr, `RSM_OFF_IRQ_MASK)) begin
            mask_q <= wr_req.data[`RSM_EV_WIDTH-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |((stat_q | ev) & mask_q);
        end
    end

    // read mux; under-voltage forces the diagnostic frame
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_resp = `RSM_RESP_OKAY;
        wr_resp = `RSM_RESP_OKAY;
        if (wr_stb && !(is_reg(wr_req.addr, `RSM_OFF_CMD)
                        || is_reg(wr_req.addr, `RSM_OFF_CHAN)
                        || is_reg(wr_req.addr, `RSM_OFF_IRQ_MASK))) begin
            wr_resp = `RSM_RESP_SLVERR;
        end
        if (!bat_good) begin
            rd_data = {29'h0, limp, 1'b0, 1'b1}; // R17
        end else if (is_reg(rd_addr, `RSM_OFF_MODE)) begin
            rd_data = {29'h0, limp, state_q};
        end else if (is_reg(rd_addr, `RSM_OFF_CHAN)) begin
            rd_data[N_CH-1:0] = chan_cfg_q;
        end else if (is_reg(rd_addr, `RSM_OFF_SUPPLY)) begin
            rd_data = {29'h0, pins.logic_ok, bat_good, limp};
        end else if (is_reg(rd_addr, `RSM_OFF_IRQ_STAT)) begin
            rd_data[`RSM_EV_WIDTH-1:0] = stat_q;
        end else if (is_reg(rd_addr, `RSM_OFF_IRQ_MASK)) begin
            rd_data[`RSM_EV_WIDTH-1:0] = mask_q;
        end else if (is_reg(rd_addr, `RSM_OFF_DIAG)) begin
            rd_data = {29'h0, limp, 1'b0, transmission_error_flag_q}; // R15
        end else if (!is_reg(rd_addr, `RSM_OFF_CMD)) begin
            rd_resp = `RSM_RESP_SLVERR;
        end
    end
endmodule // rsm_mode_ctrl

// [src/rsm_defines.svh]
// rsm_defines.svh: offsets, field positions, reset values, timing counts
// assumes inclusion by bare name from the package and design modules
`ifndef RSM_DEFINES_SVH
`define RSM_DEFINES_SVH

`define RSM_OFF_CMD        12'h000
`define RSM_OFF_MODE       12'h004
`define RSM_OFF_CHAN       12'h008
`define RSM_OFF_SUPPLY     12'h00c
`define RSM_OFF_IRQ_STAT   12'h010
`define RSM_OFF_IRQ_MASK   12'h014
`define RSM_OFF_DIAG       12'h018

`define RSM_CMD_WAKE_BIT   0
`define RSM_CMD_STANDBY_BIT 1
`define RSM_CMD_RST_BIT    2

`define RSM_EV_MODE_BIT    0
`define RSM_EV_LIMP_BIT    1
`define RSM_EV_RESET_BIT   2
`define RSM_EV_REJECT_BIT  3
`define RSM_EV_WIDTH       4

`define RSM_CHAN_RESET     8'h00
`define RSM_MASK_RESET     4'h0
`define RSM_LIMP_CH_A      3
`define RSM_LIMP_CH_B      4

`define RSM_UV_FILT_NS     1000
`define RSM_CLK_NS         40
`define RSM_UV_FILT_CYC    (`RSM_UV_FILT_NS / `RSM_CLK_NS)

`define RSM_RESP_OKAY      2'b00
`define RSM_RESP_SLVERR    2'b10

`endif

// [src/rsm_pkg.sv]
// rsm_pkg: types shared by the mode sequencer and its bus slave
// assumes rsm_defines.svh on the include path
`include "rsm_defines.svh"
package rsm_pkg;

    typedef enum logic [1:0] {
        RSM_ST_POR     = 2'b00,
        RSM_ST_STANDBY = 2'b01,
        RSM_ST_ACTIVE  = 2'b11,
        RSM_ST_LIMP    = 2'b10
    } rsm_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } rsm_wreq_t;

    typedef struct packed {
        logic wake;
        logic standby;
        logic reset;
    } rsm_cmd_t;

    typedef struct packed {
        logic bat_ok;
        logic logic_ok;
        logic limp_home_input;
        logic in1;
        logic in2;
    } rsm_pins_t;

endpackage : rsm_pkg

// [src/rsm_uv_filter.sv]
// rsm_uv_filter: qualifies a supply-good level, drops at once, rises late
// assumes the supply level is synchronous to ref_clk
`timescale 1ns/1ns
module rsm_uv_filter #(
    parameter int CYCLES = 25
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic supply_ok,
    output logic      good_q
);
    logic [15:0] cnt_q;

    // loss acts at once so outputs clear two cycles after the supply drops
    always_ff @(posedge ref_clk) begin
        if (rst || !supply_ok) begin
            cnt_q  <= 16'h0000;
            good_q <= 1'b0;
        end else if (cnt_q >= 16'(CYCLES - 1)) begin
            good_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 16'h0001;
        end
    end
endmodule // rsm_uv_filter

// [src/rsm_axil_slave.sv]
// rsm_axil_slave: axi4-lite front end, one write and one read at a time
// assumes single clock; read data is supplied combinationally by the parent
`timescale 1ns/1ns
`include "rsm_defines.svh"
module rsm_axil_slave (
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire logic [11:0]     s_awaddr,
    input  wire logic            s_awvalid,
    output logic                 s_awready,
    input  wire logic [31:0]     s_wdata,
    input  wire logic [3:0]      s_wstrb,
    input  wire logic            s_wvalid,
    output logic                 s_wready,
    output logic [1:0]           s_bresp,
    output logic                 s_bvalid,
    input  wire logic            s_bready,
    input  wire logic [11:0]     s_araddr,
    input  wire logic            s_arvalid,
    output logic                 s_arready,
    output logic [31:0]          s_rdata,
    output logic [1:0]           s_rresp,
    output logic                 s_rvalid,
    input  wire logic            s_rready,
    output rsm_pkg::rsm_wreq_t   wr_req_q,
    output logic                 wr_stb_q,
    input  wire logic [1:0]      wr_resp,
    output logic [11:0]          rd_addr_q,
    output logic                 rd_stb_q,
    input  wire logic [31:0]     rd_data,
    input  wire logic [1:0]      rd_resp
);
    import rsm_pkg::*;

    logic have_aw_q;
    logic have_w_q;

    // readies are flops so every top output is registered;
    // costs one idle cycle after each response
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_arready <= 1'b0;
        end else begin
            s_awready <= !(s_awvalid && s_awready) && !have_aw_q
                         && !s_bvalid && !wr_stb_q;
            s_wready  <= !(s_wvalid && s_wready) && !have_w_q
                         && !s_bvalid && !wr_stb_q;
            s_arready <= !(s_arvalid && s_arready) && !s_rvalid
                         && !rd_stb_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            have_aw_q <= 1'b0;
            have_w_q  <= 1'b0;
            wr_stb_q  <= 1'b0;
            wr_req_q  <= '0;
        end else begin
            wr_stb_q <= 1'b0;
            if (s_awvalid && s_awready) begin
                have_aw_q     <= 1'b1;
                wr_req_q.addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                have_w_q      <= 1'b1;
                wr_req_q.data <= s_wdata;
                wr_req_q.strb <= s_wstrb;
            end
            if (have_aw_q && have_w_q) begin
                have_aw_q <= 1'b0;
                have_w_q  <= 1'b0;
                wr_stb_q  <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_bvalid <= 1'b0;
            s_bresp  <= `RSM_RESP_OKAY;
        end else if (wr_stb_q) begin
            s_bvalid <= 1'b1;
            s_bresp  <= wr_resp;
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_stb_q  <= 1'b0;
            rd_addr_q <= 12'h000;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= `RSM_RESP_OKAY;
        end else begin
            rd_stb_q <= s_arvalid && s_arready;
            if (s_arvalid && s_arready) begin
                rd_addr_q <= s_araddr;
            end
            if (rd_stb_q) begin
                s_rvalid <= 1'b1;
                s_rdata  <= rd_data;
                s_rresp  <= rd_resp;
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end
endmodule // rsm_axil_slave

// [verification/rsm_mode_ctrl_assertions.sv]
// rsm_mode_ctrl_assertions: port-level checks of the mode sequencer
// assumes binding to rsm_mode_ctrl with a short supply filter (UV_CYC 2)
`timescale 1ns/1ns
module rsm_mode_ctrl_assertions #(
    parameter int N_CH   = 8,
    parameter int UV_CYC = 25
) (
    input wire logic               ref_clk,
    input wire logic               rst,
    input wire rsm_pkg::rsm_pins_t pins,
    input wire logic               s_awvalid,
    input wire logic               s_awready,
    input wire logic               s_wvalid,
    input wire logic               s_wready,
    input wire logic [1:0]         s_bresp,
    input wire logic               s_bvalid,
    input wire logic               s_bready,
    input wire logic               s_arvalid,
    input wire logic               s_arready,
    input wire logic [31:0]        s_rdata,
    input wire logic               s_rvalid,
    input wire logic               s_rready,
    input wire logic [N_CH-1:0]    chan_on_q
);
    import rsm_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // eight cycles covers filter, power-up step and limp entry
    sequence s_limp_on;
        (pins.bat_ok && pins.limp_home_input) [*8];
    endsequence
    sequence s_wr_taken;
        s_awvalid && s_awready && s_wvalid && s_wready;
    endsequence
    sequence s_uv_read;
        (!pins.bat_ok) [*3] ##0 (s_arvalid && s_arready);
    endsequence
    AST_UV_CHAN_OFF: assert property (
        $fell(pins.bat_ok) |-> ##[1:3] (chan_on_q == '0))
        else $error("channels still on after supply loss");
    AST_LIMP_ROUTE: assert property (
        s_limp_on |-> chan_on_q[3] == $past(pins.in1)
            && chan_on_q[4] == $past(pins.in2))
        else $error("limp inputs not routed to channels");
    AST_LIMP_REGS: assert property (
        s_limp_on |-> chan_on_q[7:5] == 3'h0 && chan_on_q[2:0] == 3'h0)
        else $error("non-limp channel on in limp home");
    AST_HOLD_NO_LOGIC: assert property (
        (pins.bat_ok && !pins.logic_ok && !pins.limp_home_input) [*4]
            |-> $stable(chan_on_q))
        else $error("outputs moved without logic supply");
    AST_UV_READ: assert property (
        s_uv_read |-> ##[1:3] (s_rvalid && s_rdata[0]))
        else $error("undervoltage read without error flag");
    AST_WR_ANSWER: assert property (
        s_wr_taken |-> ##[1:4] s_bvalid)
        else $error("write response missing");
    AST_RD_ANSWER: assert property (
        s_arvalid && s_arready |-> ##[1:3] s_rvalid)
        else $error("read response missing");
    AST_B_HOLD: assert property (
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (
        s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data dropped early");
endmodule // rsm_mode_ctrl_assertions

bind rsm_mode_ctrl rsm_mode_ctrl_assertions #(
    .N_CH(N_CH),
    .UV_CYC(UV_CYC)
) rsm_mode_ctrl_assertions_inst (.ref_clk, .rst, .pins, .s_awvalid,
    .s_awready, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_arvalid, .s_arready, .s_rdata, .s_rvalid, .s_rready, .chan_on_q);

// [verification/rsm_chain_peer.sv]
// rsm_chain_peer: next device of the serial chain, shifts random bits in
// assumes one shift enable every fourth ref_clk cycle
`timescale 1ns/1ns
module rsm_chain_peer (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic so_out_q,
    output logic      so_in = 1'b0,
    output logic      sclk_en = 1'b0,
    output int        toggles = 0
);
    logic [1:0] div_q = 2'h0;
    logic       last_q = 1'b0;
    always @(posedge ref_clk) begin
        div_q <= div_q + 2'h1;
        sclk_en <= (div_q == 2'h3);
        // fresh bit each cycle so a stuck chain cannot look alive
        so_in <= 1'($urandom);
        last_q <= so_out_q;
        if (!rst && so_out_q !== last_q) begin
            toggles <= toggles + 1;
        end
    end
endmodule // rsm_chain_peer

// [verification/relay_switch_mode_control_tb.sv]
// relay_switch_mode_control_tb: mode, limp and reset sequences
// assumes rsm_mode_ctrl with UV_CYC 2 and the byte map of the defines header
`timescale 1ns/1ns
`include "rsm_defines.svh"
module relay_switch_mode_control_tb;
    import rsm_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    rsm_pins_t   pins = 5'b11000;
    logic        so_in, sclk_en, so_out_q, irq_q;
    logic [11:0] s_awaddr = '0, s_araddr = '0;
    logic [31:0] s_wdata = '0, s_rdata;
    logic [3:0]  s_wstrb = 4'hf;
    logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0;
    logic        s_arvalid = 0, s_rready = 0;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0]  s_bresp, s_rresp;
    logic [7:0]  chan_on_q, r8;
    logic        a, b;
    logic [65:0] e;
    logic [1:0]  exp_b[$];
    logic [65:0] exp_r[$];
    int          err_total = 0;
    int          n_compared = 0;
    int          toggles;
    localparam logic [1:0] OK = `RSM_RESP_OKAY;

    always #20 ref_clk = ~ref_clk;

    rsm_mode_ctrl #(.N_CH(8), .UV_CYC(2)) rsm_mode_ctrl_inst (.ref_clk,
        .rst, .pins, .so_in, .sclk_en, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .chan_on_q, .so_out_q, .irq_q);
    rsm_chain_peer rsm_chain_peer_inst (.ref_clk, .rst, .so_out_q,
        .so_in, .sclk_en, .toggles);

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic hang();
        err_total++;
        results();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        @(posedge ref_clk);
        exp_b.push_back(r);
        s_awaddr <= ad;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (n = 0; n < 99 && !(s_bvalid && s_bready); n++) begin
            @(posedge ref_clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end
        if (n == 99) hang();
        s_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] care,
                      input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge ref_clk);
        exp_r.push_back({care, r, d & care});
        s_araddr <= ad;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (n = 0; n < 99 && !(s_rvalid && s_rready); n++) begin
            @(posedge ref_clk);
            if (s_arready) s_arvalid <= 1'b0;
        end
        if (n == 99) hang();
        s_rready <= 1'b0;
    endtask
    task automatic wait_irq();
        int n;
        for (n = 0; n < 20 && irq_q !== 1'b1; n++) @(posedge ref_clk);
        check(34'(irq_q), 34'h1);
        if (n == 20) hang();
    endtask

    // monitor: oldest note against each response as it is taken
    always @(posedge ref_clk) begin
        if (s_bvalid && s_bready) begin
            check(34'(s_bresp), 34'(exp_b.pop_front()));
        end
        if (s_rvalid && s_rready) begin
            e = exp_r.pop_front();
            check({s_rresp, s_rdata & e[65:34]}, e[33:0]);
        end
    end

    initial begin
        cyc(20000);
        hang();
    end

    initial begin
        void'($urandom(24));
        cyc(16);
        rst <= 1'b0;
        cyc(8);
        rd(`RSM_OFF_DIAG, 7, 1, OK);
        rd(`RSM_OFF_DIAG, 7, 0, OK);
        rd(`RSM_OFF_MODE, 7, 1, OK);
        rd(`RSM_OFF_CHAN, 'hff, 0, OK);
        wr(`RSM_OFF_IRQ_MASK, 1, OK);
        rd(`RSM_OFF_IRQ_MASK, 'hf, 1, OK);
        rd(`RSM_OFF_IRQ_STAT, 0, 0, OK);
        wr(`RSM_OFF_CMD, 1, OK);
        wait_irq();
        rd(`RSM_OFF_MODE, 7, 3, OK);
        rd(`RSM_OFF_IRQ_STAT, 1, 1, OK);
        cyc(3);
        check(34'(irq_q), 34'h0);
        r8 = 8'($urandom);
        wr(`RSM_OFF_CHAN, 32'(r8), OK);
        rd(`RSM_OFF_CHAN, 'hff, 32'(r8), OK);
        cyc(3);
        check(34'(chan_on_q), 34'(r8));
        wr(`RSM_OFF_IRQ_MASK, 0, OK);
        wr(`RSM_OFF_CMD, 2, OK);
        cyc(3);
        check(34'(irq_q), 34'h0);
        rd(`RSM_OFF_MODE, 7, 1, OK);
        rd(`RSM_OFF_CHAN, 'hff, 0, OK);
        check(34'(chan_on_q), 34'h0);
        a = 1'($urandom);
        b = 1'($urandom);
        pins.in1 <= a;
        pins.in2 <= b;
        pins.limp_home_input <= 1'b1;
        cyc(10);
        rd(`RSM_OFF_MODE, 7, 6, OK);
        check(34'(chan_on_q), 34'({b, a, 3'h0}));
        wr(`RSM_OFF_CMD, 1, OK);
        wr(`RSM_OFF_CHAN, 'hff, OK);
        rd(`RSM_OFF_MODE, 7, 6, OK);
        rd(`RSM_OFF_CHAN, 'hff, 0, OK);
        rd(`RSM_OFF_DIAG, 5, 5, OK);
        rd(`RSM_OFF_IRQ_STAT, 'hf, 'hb, OK);
        pins.logic_ok <= 1'b0;
        cyc(4);
        check(34'(chan_on_q), 34'({b, a, 3'h0}));
        pins.logic_ok <= 1'b1;
        pins.limp_home_input <= 1'b0;
        cyc(6);
        rd(`RSM_OFF_MODE, 7, 1, OK);
        wr(`RSM_OFF_CMD, 1, OK);
        wr(`RSM_OFF_CHAN, 32'(r8), OK);
        cyc(3);
        pins.logic_ok <= 1'b0;
        wr(`RSM_OFF_CHAN, 32'(~r8), OK);
        cyc(6);
        check(34'(chan_on_q), 34'(r8));
        pins.logic_ok <= 1'b1;
        pins.bat_ok <= 1'b0;
        cyc(4);
        check(34'(chan_on_q), 34'h0);
        rd(`RSM_OFF_MODE, 7, 1, OK);
        pins.bat_ok <= 1'b1;
        cyc(8);
        rd(`RSM_OFF_DIAG, 7, 1, OK);
        rd(`RSM_OFF_MODE, 7, 1, OK);
        rd(`RSM_OFF_SUPPLY, 7, 6, OK);
        wr(`RSM_OFF_CMD, 1, OK);
        wr(`RSM_OFF_CHAN, 32'(r8), OK);
        wr(`RSM_OFF_CMD, 4, OK);
        cyc(6);
        check(34'(chan_on_q), 34'h0);
        rd(`RSM_OFF_DIAG, 7, 1, OK);
        rd(12'h020, '1, 0, `RSM_RESP_SLVERR);
        wr(12'h020, 0, `RSM_RESP_SLVERR);
        check(34'(toggles != 0), 34'h1);
        cyc(4);
        results();
    end
endmodule // relay_switch_mode_control_tb
